/* File: verilog/agc_decay_pkg.sv */
/*
 * Shared definitions for the right-channel decay time and ADC path
 * control bank: register indices, field layouts, reset values and
 * the decay time lookups.
 * Assumes registers sit one per aligned 32-bit word on APB, with the
 * byte address four times the register index.
 */
package agc_decay_pkg;

   localparam int IDX_W      = 10;
   localparam int REG_W      = 8;
   localparam int DECAY_MS_W = 16;
   localparam int RATIO_W    = 4;
   localparam int IRQ_W      = 2;

   // Register indices; byte address is four times the index.
   localparam logic [IDX_W-1:0] DECAY_IDX    = 10'h06a;
   localparam logic [IDX_W-1:0] PATH_IDX     = 10'h06b;
   localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 10'h080;
   localparam logic [IDX_W-1:0] IRQ_EN_IDX   = 10'h081;
   localparam logic [IDX_W-1:0] IRQ_CLR_IDX  = 10'h082;

   localparam logic [REG_W-1:0] DECAY_RST = 8'h00;
   localparam logic [REG_W-1:0] PATH_RST  = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;

   localparam int IRQ_BUS_ERR = 0;
   localparam int IRQ_CAPPED  = 1;

   // Baseline decay times in milliseconds.
   localparam logic [DECAY_MS_W-1:0] BASE0_MS = 16'h0032;
   localparam logic [DECAY_MS_W-1:0] BASE1_MS = 16'h0096;
   localparam logic [DECAY_MS_W-1:0] BASE2_MS = 16'h00fa;
   localparam logic [DECAY_MS_W-1:0] BASE3_MS = 16'h015e;

   // Decay ceilings in milliseconds: 4, 5.6, 8, 9.6, 11.2, 16, 19.2
   // and 22.4 seconds.
   localparam logic [DECAY_MS_W-1:0] CAP_4S0_MS  = 16'h0fa0;
   localparam logic [DECAY_MS_W-1:0] CAP_5S6_MS  = 16'h15e0;
   localparam logic [DECAY_MS_W-1:0] CAP_8S0_MS  = 16'h1f40;
   localparam logic [DECAY_MS_W-1:0] CAP_9S6_MS  = 16'h2580;
   localparam logic [DECAY_MS_W-1:0] CAP_11S2_MS = 16'h2bc0;
   localparam logic [DECAY_MS_W-1:0] CAP_16S0_MS = 16'h3e80;
   localparam logic [DECAY_MS_W-1:0] CAP_19S2_MS = 16'h4b00;
   localparam logic [DECAY_MS_W-1:0] CAP_22S4_MS = 16'h5780;

   // Decimation ratio is carried as twice the ratio.
   localparam logic [RATIO_W-1:0] RATIO_1_0 = 4'h2;
   localparam logic [RATIO_W-1:0] RATIO_1_5 = 4'h3;
   localparam logic [RATIO_W-1:0] RATIO_2_0 = 4'h4;
   localparam logic [RATIO_W-1:0] RATIO_2_5 = 4'h5;
   localparam logic [RATIO_W-1:0] RATIO_3_0 = 4'h6;
   localparam logic [RATIO_W-1:0] RATIO_3_5 = 4'h7;
   localparam logic [RATIO_W-1:0] RATIO_4_0 = 4'h8;
   localparam logic [RATIO_W-1:0] RATIO_4_5 = 4'h9;
   localparam logic [RATIO_W-1:0] RATIO_5_0 = 4'ha;

   typedef enum logic [1:0] {
      MIC_DIG_BOTH  = 2'h0,
      MIC_LDIG_RANA = 2'h1,
      MIC_LANA_RDIG = 2'h2,
      MIC_ANA_BOTH  = 2'h3
   } mic_src_t;

   typedef struct packed {
      logic       from_reg;
      logic [1:0] base;
      logic [2:0] mult;
      logic [1:0] rsvd;
   } decay_cfg_t;

   typedef struct packed {
      logic     hp_left_prog;
      logic     hp_right_prog;
      mic_src_t mic_src;
      logic     prog_filt;
      logic     detect_off;
      logic     rsvd;
      logic     bus_err;
   } path_cfg_t;

   function automatic logic [DECAY_MS_W-1:0] base_ms(
      input logic [1:0] code);
      case (code)
         2'h0:    base_ms = BASE0_MS;
         2'h1:    base_ms = BASE1_MS;
         2'h2:    base_ms = BASE2_MS;
         default: base_ms = BASE3_MS;
      endcase
   endfunction

   // Ratios outside the table get the widest ceiling.
   function automatic logic [DECAY_MS_W-1:0] cap_ms(
      input logic [RATIO_W-1:0] ratio);
      case (ratio)
         RATIO_1_0:            cap_ms = CAP_4S0_MS;
         RATIO_1_5:            cap_ms = CAP_5S6_MS;
         RATIO_2_0:            cap_ms = CAP_8S0_MS;
         RATIO_2_5:            cap_ms = CAP_9S6_MS;
         RATIO_3_0, RATIO_3_5: cap_ms = CAP_11S2_MS;
         RATIO_4_0, RATIO_4_5: cap_ms = CAP_16S0_MS;
         RATIO_5_0:            cap_ms = CAP_19S2_MS;
         default:              cap_ms = CAP_22S4_MS;
      endcase
   endfunction

endpackage

/* File: verilog/decay_time_calc.sv */
/*
 * Combinational decay time computation: baseline times factor, or
 * the legacy value, limited by the decimation ratio ceiling.
 * Assumes the legacy decay time arrives already in milliseconds.
 */
`timescale 1ns/1ps
module decay_time_calc (
   // Configuration
   input  wire agc_decay_pkg::decay_cfg_t     cfg,
   input  wire logic [15:0]                   legacy_decay_ms,
   input  wire logic [3:0]                    ratio_x2,
   // Result
   output logic [15:0]                        decay_ms,
   output logic                               capped
);
   import agc_decay_pkg::*;

   logic [DECAY_MS_W-1:0] scaled;
   logic [DECAY_MS_W-1:0] raw;
   logic [DECAY_MS_W-1:0] ceiling;

   // The largest product, 350 ms times 128, still fits in 16 bits.
   always_comb begin
      scaled   = base_ms(cfg.base) << cfg.mult;  // [RULE2] [RULE3] [RULE4]
      raw      = cfg.from_reg ? scaled : legacy_decay_ms;  // [RULE1]
      ceiling  = cap_ms(ratio_x2);  // [RULE5]
      capped   = raw > ceiling;
      decay_ms = capped ? ceiling : raw;  // [RULE5]
   end

endmodule

/* File: verilog/agc_decay_adc_path_config.sv */
/*
 * APB register bank for the right AGC decay time and the ADC digital
 * path, with the bus error status and a small interrupt block.
 * Assumes the bus error monitor gives a one-cycle pulse per error and
 * that all inputs are synchronous to core_clk.
 */
// Summary of operation
// RULE1 - Source bit low takes legacy decay time, high takes this register.
// RULE2 - Baseline codes 0 to 3 give 50, 150, 250, 350 ms.
// RULE3 - Multiplier field gives factor two to the power of its code.
// RULE4 - Decay time is baseline times factor.
// RULE5 - Decay time is limited by a ceiling set by decimation ratio.
// RULE6 - Host writes zeros to the two low decay register bits.
// RULE7 - Left high-pass uses programmable coefficients when bit 7 set.
// RULE8 - Right high-pass uses programmable coefficients when bit 6 set.
// RULE9 - Two-bit field picks digital or analog microphone per channel.
// RULE10 - Bit 3 inserts programmable filter on ADC output if DACs are off.
// RULE11 - Bit 2 low enables bus error detection and clearing.
// RULE12 - Bus error status bit reads one after an error, read clears it.
`timescale 1ns/1ps
module agc_decay_adc_path_config #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ADDR_W-1:0]           paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic                             pready,
   output logic [31:0]                      prdata,
   output logic                             pslverr,
   // Codec state
   input  wire logic [15:0]                 legacy_decay_ms,
   input  wire logic [3:0]                  adc_decimation_ratio,
   input  wire logic                        dac_left_powered,
   input  wire logic                        dac_right_powered,
   input  wire logic                        bus_err_seen,
   // Decay and path controls
   output logic [15:0]                      decay_ms,
   output logic                             decay_capped,
   output logic                             hp_left_prog,
   output logic                             hp_right_prog,
   output agc_decay_pkg::mic_src_t          mic_src,
   output logic                             left_mic_analog,
   output logic                             right_mic_analog,
   output logic                             prog_filter_on_adc,
   output logic                             bus_err_detect_en,
   output logic                             bus_err_clear,
   // Interrupt
   output logic                             irq
);
   import agc_decay_pkg::*;

   localparam int WORD_W = ADDR_W - 2;

   function automatic logic is_analog(input mic_src_t src,
                                      input logic right);
      is_analog = right ? src[0] : src[1];
   endfunction

   function automatic logic hit(input logic [WORD_W-1:0] word,
                                input logic [IDX_W-1:0] idx);
      hit = word == WORD_W'(idx);
   endfunction

   decay_cfg_t            decay_reg;
   decay_cfg_t            decay_next;
   path_cfg_t             path_reg;
   path_cfg_t             path_next;
   path_cfg_t             wr_path;
   path_cfg_t             rd_path;
   logic [IRQ_W-1:0]      irq_en_reg;
   logic [IRQ_W-1:0]      irq_en_next;
   logic [IRQ_W-1:0]      irq_stat_reg;
   logic [IRQ_W-1:0]      irq_stat_next;
   logic [IRQ_W-1:0]      events;
   logic [31:0]           prdata_reg;
   logic [31:0]           prdata_next;

   logic [15:0]           decay_ms_reg;
   logic [15:0]           decay_ms_next;
   logic                  capped_reg;
   logic                  capped_next;
   logic                  hp_left_reg;
   logic                  hp_left_next;
   logic                  hp_right_reg;
   logic                  hp_right_next;
   mic_src_t              mic_src_reg;
   mic_src_t              mic_src_next;
   logic                  left_ana_reg;
   logic                  left_ana_next;
   logic                  right_ana_reg;
   logic                  right_ana_next;
   logic                  prog_filt_reg;
   logic                  prog_filt_next;
   logic                  detect_en_reg;
   logic                  detect_en_next;
   logic                  err_clear_reg;
   logic                  err_clear_next;

   logic [WORD_W-1:0]     word;
   logic                  setup;
   logic                  access;
   logic                  mapped;
   logic                  wr_fire;
   logic                  rd_fire;
   logic                  err_set;
   logic [15:0]           calc_ms;
   logic                  calc_capped;

   assign word    = paddr[ADDR_W-1:2];
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign mapped  = hit(word, DECAY_IDX) || hit(word, PATH_IDX) ||
                    hit(word, IRQ_STAT_IDX) || hit(word, IRQ_EN_IDX) ||
                    hit(word, IRQ_CLR_IDX);
   // Only byte lane 0 carries register data, so pstrb[0] gates writes.
   assign wr_fire = access && pwrite && pstrb[0] && mapped;
   assign rd_fire = access && !pwrite;
   assign wr_path = path_cfg_t'(pwdata[REG_W-1:0]);
   // A read clears only the status it returned, so a newer error survives.
   assign rd_path = path_cfg_t'(prdata_reg[REG_W-1:0]);

   // A detection that lands while detection is off is simply dropped.
   assign err_set = bus_err_seen && !path_reg.detect_off;  // [RULE11]
   assign events[IRQ_BUS_ERR] = err_set;
   assign events[IRQ_CAPPED]  = calc_capped && !capped_reg;

   decay_time_calc u_calc (
      .cfg             (decay_reg),
      .legacy_decay_ms (legacy_decay_ms),
      .ratio_x2        (adc_decimation_ratio),
      .decay_ms        (calc_ms),
      .capped          (calc_capped)
   );

   // Register file and bus answer.
   always_comb begin
      decay_next    = decay_reg;
      path_next     = path_reg;
      irq_en_next   = irq_en_reg;
      irq_stat_next = irq_stat_reg;
      prdata_next   = prdata_reg;
      if (wr_fire && hit(word, DECAY_IDX)) begin
         // Low two bits are stored as written; the host keeps them zero.
         decay_next = decay_cfg_t'(pwdata[REG_W-1:0]);  // [RULE6]
      end
      if (wr_fire && hit(word, PATH_IDX)) begin
         path_next.hp_left_prog  = wr_path.hp_left_prog;
         path_next.hp_right_prog = wr_path.hp_right_prog;
         path_next.mic_src       = wr_path.mic_src;
         path_next.prog_filt     = wr_path.prog_filt;
         path_next.detect_off    = wr_path.detect_off;
      end
      if (wr_fire && hit(word, IRQ_EN_IDX)) begin
         irq_en_next = pwdata[IRQ_W-1:0];
      end
      if (wr_fire && hit(word, IRQ_CLR_IDX)) begin
         irq_stat_next = irq_stat_reg & ~pwdata[IRQ_W-1:0];
      end
      if (rd_fire && hit(word, PATH_IDX)) begin
         path_next.bus_err = path_reg.bus_err && !rd_path.bus_err;  // [RULE12]
      end
      // A new error in the clearing cycle must not be lost.
      if (err_set) begin
         path_next.bus_err = 1'b1;  // [RULE12]
      end
      irq_stat_next = irq_stat_next | events;
      if (setup) begin
         prdata_next = '0;
         if (hit(word, DECAY_IDX)) begin
            prdata_next[REG_W-1:0] = decay_reg;
         end
         if (hit(word, PATH_IDX)) begin
            prdata_next[REG_W-1:0] = path_reg;
         end
         if (hit(word, IRQ_STAT_IDX)) begin
            prdata_next[IRQ_W-1:0] = irq_stat_reg;
         end
         if (hit(word, IRQ_EN_IDX)) begin
            prdata_next[IRQ_W-1:0] = irq_en_reg;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         decay_reg    <= decay_cfg_t'(DECAY_RST);
         path_reg     <= path_cfg_t'(PATH_RST);
         irq_en_reg   <= IRQ_RST;
         irq_stat_reg <= IRQ_RST;
         prdata_reg   <= '0;
      end else begin
         decay_reg    <= decay_next;
         path_reg     <= path_next;
         irq_en_reg   <= irq_en_next;
         irq_stat_reg <= irq_stat_next;
         prdata_reg   <= prdata_next;
      end
   end

   // Outputs toward the audio path.
   always_comb begin
      decay_ms_next  = calc_ms;  // [RULE1] [RULE4] [RULE5]
      capped_next    = calc_capped;
      hp_left_next   = path_reg.hp_left_prog;  // [RULE7]
      hp_right_next  = path_reg.hp_right_prog;  // [RULE8]
      mic_src_next   = path_reg.mic_src;  // [RULE9]
      left_ana_next  = is_analog(path_reg.mic_src, 1'b0);  // [RULE9]
      right_ana_next = is_analog(path_reg.mic_src, 1'b1);  // [RULE9]
      // The filter is shared with playback, so any live DAC wins it.
      prog_filt_next = path_reg.prog_filt && !dac_left_powered &&
                       !dac_right_powered;  // [RULE10]
      detect_en_next = !path_reg.detect_off;  // [RULE11]
      err_clear_next = err_set;  // [RULE11]
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         decay_ms_reg  <= '0;
         capped_reg    <= 1'b0;
         hp_left_reg   <= 1'b0;
         hp_right_reg  <= 1'b0;
         mic_src_reg   <= MIC_DIG_BOTH;
         left_ana_reg  <= 1'b0;
         right_ana_reg <= 1'b0;
         prog_filt_reg <= 1'b0;
         detect_en_reg <= 1'b0;
         err_clear_reg <= 1'b0;
      end else begin
         decay_ms_reg  <= decay_ms_next;
         capped_reg    <= capped_next;
         hp_left_reg   <= hp_left_next;
         hp_right_reg  <= hp_right_next;
         mic_src_reg   <= mic_src_next;
         left_ana_reg  <= left_ana_next;
         right_ana_reg <= right_ana_next;
         prog_filt_reg <= prog_filt_next;
         detect_en_reg <= detect_en_next;
         err_clear_reg <= err_clear_next;
      end
   end

   assign pready             = 1'b1;
   assign pslverr            = access && !mapped;
   assign prdata             = prdata_reg;
   assign decay_ms           = decay_ms_reg;
   assign decay_capped       = capped_reg;
   assign hp_left_prog       = hp_left_reg;
   assign hp_right_prog      = hp_right_reg;
   assign mic_src            = mic_src_reg;
   assign left_mic_analog    = left_ana_reg;
   assign right_mic_analog   = right_ana_reg;
   assign prog_filter_on_adc = prog_filt_reg;
   assign bus_err_detect_en  = detect_en_reg;
   assign bus_err_clear      = err_clear_reg;
   assign irq                = |(irq_stat_reg & irq_en_reg);

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence path_read_done;
      rd_fire && hit(word, PATH_IDX) && rd_path.bus_err && !err_set;
   endsequence

   sequence error_caught;
      bus_err_seen && !path_reg.detect_off;
   endsequence

   legacy_source_a: assert property ( // [RULE1]
      !decay_reg.from_reg && !calc_capped
      |=> decay_ms == $past(legacy_decay_ms))
      else $error("legacy decay time not passed through");

   baseline_map_a: assert property ( // [RULE2]
      decay_reg.from_reg && decay_reg.mult == 3'h0
      |=> decay_ms == $past(base_ms(decay_reg.base)))
      else $error("baseline decay time wrong");

   factor_scale_a: assert property ( // [RULE3] [RULE4]
      decay_reg.from_reg && !calc_capped
      |=> decay_ms == 16'($past(base_ms(decay_reg.base)) <<
                          $past(decay_reg.mult)))
      else $error("decay time not baseline times factor");

   ceiling_hold_a: assert property ( // [RULE5]
      ##1 decay_ms <= $past(cap_ms(adc_decimation_ratio)))
      else $error("decay time above ratio ceiling");

   coef_select_a: assert property ( // [RULE7] [RULE8]
      ##1 hp_left_prog == $past(path_reg.hp_left_prog) &&
          hp_right_prog == $past(path_reg.hp_right_prog))
      else $error("high-pass coefficient select wrong");

   mic_source_a: assert property ( // [RULE9]
      ##1 left_mic_analog == $past(path_reg.mic_src[1]) &&
          right_mic_analog == $past(path_reg.mic_src[0]))
      else $error("microphone source decode wrong");

   filter_insert_a: assert property ( // [RULE10]
      (dac_left_powered || dac_right_powered) |=> !prog_filter_on_adc)
      else $error("programmable filter inserted with a DAC on");

   detect_off_a: assert property ( // [RULE11]
      path_reg.detect_off |=> !bus_err_clear)
      else $error("bus error cleared while detection disabled");

   detect_on_a: assert property ( // [RULE11] [RULE12]
      error_caught |=> bus_err_clear && path_reg.bus_err
                       ##1 bus_err_clear == $past(err_set))
      else $error("bus error not caught and cleared");

   read_clear_a: assert property ( // [RULE12]
      path_read_done |=> !path_reg.bus_err)
      else $error("bus error status survived a read");

   filter_on_a: assert property ( // [RULE10]
      path_reg.prog_filt && !dac_left_powered && !dac_right_powered
      |=> prog_filter_on_adc)
      else $error("programmable filter not inserted with DACs off");

   unmapped_error_a: assert property (
      access && !mapped |-> pslverr)
      else $error("unmapped access without error response");

   cap_event_a: assert property (
      calc_capped && !capped_reg |=> irq_stat_reg[IRQ_CAPPED])
      else $error("decay ceiling onset not recorded");

   irq_clear_a: assert property (
      wr_fire && hit(word, IRQ_CLR_IDX) && pwdata[IRQ_BUS_ERR] && !err_set
      |=> !irq_stat_reg[IRQ_BUS_ERR])
      else $error("interrupt status not cleared by write");

   irq_level_a: assert property (
      irq_stat_reg[IRQ_BUS_ERR] && irq_en_reg[IRQ_BUS_ERR] |-> irq)
      else $error("enabled status does not raise interrupt");

endmodule

/* File: verif/apb_host_model.sv */
/*
 * Host model: an APB master that issues one transfer at a time.
 * Assumes one clock and a slave that answers through pready.
 */
`timescale 1ns/1ps
module apb_host_model (
   // Clock
   input  wire logic        core_clk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      pstrb   = 4'h0;
   end

   // An edge always passes first, so back-to-back calls never drive
   // the strobes twice in one time step.
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= (a == 12'h1a8) ? (d & 32'hfffffffc) : d;
      pstrb   <= 4'hf;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

/* File: verif/agc_decay_adc_path_config_tb_top.sv */
/*
 * Self-checking bench for the decay time and ADC path register bank.
 * Assumes the APB host model and the bank share core_clk.
 */
`timescale 1ns/1ps
module agc_decay_adc_path_config_tb_top;
   import agc_decay_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst, psel, penable, pwrite, pready, pslverr, erv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv, e_v, g_v, src;
   logic [3:0]  pstrb, adc_decimation_ratio;
   logic [15:0] legacy_decay_ms, decay_ms;
   logic        dac_left_powered, dac_right_powered, bus_err_seen;
   logic        decay_capped, hp_left_prog, hp_right_prog, irq;
   logic        left_mic_analog, right_mic_analog, prog_filter_on_adc;
   logic        bus_err_detect_en, bus_err_clear;
   logic [7:0]  rnd = 8'h3c;
   logic [7:0]  v;
   mic_src_t    mic_src;
   logic [31:0] exp_q[$];
   logic [31:0] got_q[$];
   int          error_cnt = 0;
   int          checks = 0;
   int          cyc = 0;

   always #25 core_clk = ~core_clk;

   agc_decay_adc_path_config agc_decay_adc_path_config_i (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .legacy_decay_ms(legacy_decay_ms),
      .adc_decimation_ratio(adc_decimation_ratio),
      .dac_left_powered(dac_left_powered),
      .dac_right_powered(dac_right_powered),
      .bus_err_seen(bus_err_seen), .decay_ms(decay_ms),
      .decay_capped(decay_capped), .hp_left_prog(hp_left_prog),
      .hp_right_prog(hp_right_prog), .mic_src(mic_src),
      .left_mic_analog(left_mic_analog),
      .right_mic_analog(right_mic_analog),
      .prog_filter_on_adc(prog_filter_on_adc),
      .bus_err_detect_en(bus_err_detect_en),
      .bus_err_clear(bus_err_clear), .irq(irq));

   apb_host_model apb_host_model_i (
      .core_clk(core_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   function automatic logic [31:0] base_of(input logic [1:0] b);
      case (b)
         2'h0:    return 32'h0032;
         2'h1:    return 32'h0096;
         2'h2:    return 32'h00fa;
         default: return 32'h015e;
      endcase
   endfunction

   function automatic logic [31:0] cap_of(input logic [3:0] r);
      case (r)
         4'h2:       return 32'h0fa0;
         4'h3:       return 32'h15e0;
         4'h4:       return 32'h1f40;
         4'h5:       return 32'h2580;
         4'h6, 4'h7: return 32'h2bc0;
         4'h8, 4'h9: return 32'h3e80;
         4'ha:       return 32'h4b00;
         default:    return 32'h5780;
      endcase
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Results are noted beside their expectations; the watcher pairs them.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      exp_q.push_back(exp);
      got_q.push_back(got);
   endtask

   always @(posedge core_clk) begin
      while (got_q.size() > 0) begin
         e_v = exp_q.pop_front();
         g_v = got_q.pop_front();
         checks++;
         if (g_v !== e_v) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g_v, e_v);
         end
      end
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb_host_model_i.xfer(1'b1, a, d, rdv, erv);
   endtask

   // Only the unmapped probe address may raise the error response.
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb_host_model_i.xfer(1'b0, a, 32'h0, rdv, erv);
      chk(rdv, e);
      chk({31'h0, erv}, {31'h0, a == 12'h3fc});
   endtask

   task automatic err_pulse(input logic e);
      @(posedge core_clk);
      bus_err_seen <= 1'b1;
      @(posedge core_clk);
      bus_err_seen <= 1'b0;
      #1;
      chk({31'h0, bus_err_clear}, {31'h0, e});
   endtask

   initial begin
      rst = 1'b1;
      legacy_decay_ms = 16'h0100;
      adc_decimation_ratio = 4'hc;
      dac_left_powered = 1'b1;
      dac_right_powered = 1'b1;
      bus_err_seen = 1'b0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      wait_cyc(3);
      chk({16'h0, decay_ms}, 32'h0100);
      chk({31'h0, bus_err_detect_en}, 32'h1);
      rd(12'h1a8, 32'h0);
      rd(12'h1ac, 32'h0);
      rd(12'h204, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         @(posedge core_clk);
         legacy_decay_ms <= {4'h0, rnd, 4'h0};
         wait_cyc(3);
         chk({16'h0, decay_ms}, {20'h0, rnd, 4'h0});
         chk({31'h0, decay_capped}, 32'h0);
      end
      for (int b = 0; b < 4; b++) begin
         for (int m = 0; m < 8; m++) begin
            wr(12'h1a8, {24'h0, 1'b1, b[1:0], m[2:0], 2'h3});
            wait_cyc(3);
            src = base_of(b[1:0]) << m;
            if (src > 32'h5780) begin
               src = 32'h5780;
            end
            chk({16'h0, decay_ms}, src);
            rd(12'h1a8, {24'h0, 1'b1, b[1:0], m[2:0], 2'h0});
         end
      end
      $display("test decay done");
      wr(12'h1a8, 32'h000000fc);
      for (int r = 2; r < 13; r++) begin
         @(posedge core_clk);
         adc_decimation_ratio <= r[3:0];
         wait_cyc(3);
         chk({16'h0, decay_ms}, cap_of(r[3:0]));
         chk({31'h0, decay_capped}, 32'h1);
      end
      wr(12'h1a8, 32'h0);
      wait_cyc(3);
      chk({16'h0, decay_ms}, {20'h0, rnd, 4'h0});
      rd(12'h200, 32'h2);
      $display("test ceiling done");
      for (int mc = 0; mc < 4; mc++) begin
         rnd = lfsr(rnd);
         v = {rnd[7:6], mc[1:0], 1'b0, rnd[2], rnd[1:0]};
         wr(12'h1ac, {24'h0, v});
         wait_cyc(3);
         chk({31'h0, hp_left_prog}, {31'h0, v[7]});
         chk({31'h0, hp_right_prog}, {31'h0, v[6]});
         chk({28'h0, mic_src, left_mic_analog, right_mic_analog},
             {28'h0, v[5:4], v[5], v[4]});
         chk({31'h0, bus_err_detect_en}, {31'h0, !v[2]});
         rd(12'h1ac, {24'h0, v[7:2], 2'h0});
      end
      wr(12'h1ac, 32'h08);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         {dac_left_powered, dac_right_powered} <= i[1:0];
         wait_cyc(3);
         chk({31'h0, prog_filter_on_adc}, {31'h0, i == 0});
      end
      @(posedge core_clk);
      {dac_left_powered, dac_right_powered} <= 2'h0;
      wr(12'h1ac, 32'h0);
      wait_cyc(3);
      chk({31'h0, prog_filter_on_adc}, 32'h0);
      $display("test path done");
      wr(12'h208, 32'h3);
      wr(12'h204, 32'h1);
      err_pulse(1'b1);
      chk({31'h0, irq}, 32'h1);
      rd(12'h1ac, 32'h1);
      rd(12'h1ac, 32'h0);
      rd(12'h200, 32'h1);
      wr(12'h204, 32'h0);
      wait_cyc(1);
      chk({31'h0, irq}, 32'h0);
      wr(12'h204, 32'h1);
      wait_cyc(1);
      chk({31'h0, irq}, 32'h1);
      wr(12'h208, 32'h1);
      rd(12'h200, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(12'h1ac, 32'h04);
      err_pulse(1'b0);
      rd(12'h1ac, 32'h04);
      rd(12'h3fc, 32'h0);
      $display("test bus error done");
      wait_cyc(2);
      finish_test();
   end
endmodule
